// >>> verification/pmd_digital_io_bench.sv
// Self-checking bench for the pack monitor digital input/output block.
`timescale 1ns/100ps
`default_nettype none
module pmd_digital_io_bench;
   import pmd_pkg::*;
   // ==========================================================================
   // Signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata, rdata;
   logic pready, pslverr, rerr;
   logic [11:0] t_int = 12'h000;
   logic [11:0] t_one = 12'h022;
   logic [11:0] t_two = 12'h033;
   logic [11:0] t_three = 12'h044;
   logic over_volt = 1'b0;
   logic overload = 1'b0;
   logic press = 1'b0;
   logic aux_lvl = 1'b0;
   logic button_input, aux_input, out1, out2, oe1, oe2, term1, term2;
   logic button_active, aux_active, wake_request;
   int err_total = 0;
   int total_checks = 0;
   always #2.5 pclk = ~pclk;
   pmd_digital_io dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .temp_internal(t_int),
      .external_temp_first(t_one), .external_temp_second(t_two),
      .external_temp_third(t_three), .over_volt(over_volt), .overload(overload),
      .button_input(button_input), .aux_input(aux_input), .general_output_one(out1),
      .general_output_two(out2), .general_output_one_oe(oe1), .general_output_two_oe(oe2),
      .button_active(button_active), .aux_active(aux_active), .wake_request(wake_request));
   pmd_pins_model pins (.press(press), .aux_level(aux_lvl), .out_one(out1),
      .out_one_oe(oe1), .out_two(out2), .out_two_oe(oe2), .button_input(button_input),
      .aux_input(aux_input), .term_one(term1), .term_two(term2));
   // ==========================================================================
   // Shared tasks
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Setup starts one edge after entry, so a release never meets the next setup.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The wait ends on pready; a slave that never answers is left to the watchdog, so the run still reaches the verdict.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rdata, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic set_cond(input int k, input logic on);
      @(posedge pclk);
      case (k)
         1: t_int <= on ? 12'h060 : 12'h010;
         2: over_volt <= on;
         default: overload <= on;
      endcase
   endtask
   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      rd(PMD_OFF_OUT_CFG, 32'h0000_0000);
      rd(PMD_OFF_IN_CFG, 32'h0000_0002);
      rd(PMD_OFF_TEMP_SEL, 32'h0000_0001);
      check({31'h0, oe1 | oe2}, 32'h0);
      apb(1'b0, 12'h020, 32'h0000_0000);
      check({31'h0, rerr}, 32'h1);
   endtask
   task automatic t_triggers();
      wr(PMD_OFF_TEMP_LIMIT, 32'h0000_0050);
      for (int k = 1; k <= 3; k++) begin
         wr(PMD_OFF_OUT_CFG, k);
         set_cond(k % 3 + 1, 1'b1);
         cyc(4);
         check({31'h0, oe1}, 32'h0);
         set_cond(k, 1'b1);
         cyc(4);
         check({31'h0, oe1}, 32'h1);
         check({31'h0, term1}, 32'h0);
         set_cond(k, 1'b0);
         set_cond(k % 3 + 1, 1'b0);
         cyc(4);
         check({31'h0, oe1}, 32'h0);
         check({31'h0, term1}, 32'h1);
      end
   endtask
   task automatic t_never();
      wr(PMD_OFF_OUT_CFG, 32'h0000_0000);
      set_cond(2, 1'b1);
      set_cond(3, 1'b1);
      cyc(4);
      check({30'h0, oe2, oe1}, 32'h0);
      wr(PMD_OFF_OUT_CMD, 32'h0000_0003);
      cyc(4);
      check({31'h0, oe1}, 32'h1);
      rd(PMD_OFF_OUT_STAT, 32'h0000_0001);
      wr(PMD_OFF_OUT_CMD, 32'h0000_000c);
      rd(PMD_OFF_OUT_STAT, 32'h0000_0003);
      wr(PMD_OFF_OUT_CMD, 32'h0000_0002);
      cyc(4);
      check({30'h0, oe2, oe1}, 32'h2);
      check({31'h0, term2}, 32'h0);
      rd(PMD_OFF_OUT_STAT, 32'h0000_0002);
      wr(PMD_OFF_OUT_CMD, 32'h0000_0008);
      set_cond(2, 1'b0);
      set_cond(3, 1'b0);
   endtask
   task automatic t_pol();
      wr(PMD_OFF_OUT_CFG, 32'h0000_0004);
      rd(PMD_OFF_OUT_CFG, 32'h0000_0004);
      wr(PMD_OFF_OUT_CFG, 32'h0000_0040);
      rd(PMD_OFF_OUT_CFG, 32'h0000_0040);
      wr(PMD_OFF_OUT_CFG, 32'h0000_0000);
   endtask
   task automatic t_hyst();
      wr(PMD_OFF_TEMP_LIMIT, 32'h000a_0064);
      wr(PMD_OFF_OUT_CFG, 32'h0000_0001);
      @(posedge pclk);
      t_int <= 12'h065;
      cyc(5);
      check({31'h0, oe1}, 32'h1);
      @(posedge pclk);
      t_int <= 12'h05f;
      cyc(5);
      check({31'h0, oe1}, 32'h1);
      @(posedge pclk);
      t_int <= 12'h059;
      cyc(5);
      check({31'h0, oe1}, 32'h0);
      wr(PMD_OFF_OUT_CFG, 32'h0000_0000);
   endtask
   task automatic t_inputs();
      @(posedge pclk);
      press <= 1'b1;
      aux_lvl <= 1'b1;
      cyc(4);
      check({30'h0, button_active, wake_request}, 32'h3);
      check({31'h0, aux_active}, 32'h0);
      @(posedge pclk);
      press <= 1'b0;
      cyc(4);
      check({31'h0, wake_request}, 32'h0);
      wr(PMD_OFF_IN_CFG, 32'h0000_0012);
      cyc(4);
      check({31'h0, aux_active}, 32'h1);
      wr(PMD_OFF_IN_CFG, 32'h0000_0112);
      cyc(4);
      check({31'h0, aux_active}, 32'h0);
      @(posedge pclk);
      aux_lvl <= 1'b0;
      cyc(4);
      check({31'h0, aux_active}, 32'h1);
      check({31'h0, wake_request}, 32'h0);
      wr(PMD_OFF_IN_CFG, 32'h0000_0312);
      cyc(4);
      check({31'h0, wake_request}, 32'h1);
      // Lane one is masked and the aux function code is out of range, so both stay.
      pstrb <= 4'h1;
      wr(PMD_OFF_IN_CFG, 32'h0000_00f2);
      pstrb <= 4'hf;
      rd(PMD_OFF_IN_CFG, 32'h0000_0312);
   endtask
   task automatic t_temp();
      logic [11:0] tbl [4];
      @(posedge pclk);
      t_int <= 12'h011;
      tbl = '{12'h011, 12'h022, 12'h033, 12'h044};
      for (int i = 1; i <= 4; i++) begin
         wr(PMD_OFF_TEMP_SEL, i);
         rd(PMD_OFF_TEMP_READ, {20'h0, tbl[i-1]});
      end
      wr(PMD_OFF_TEMP_SEL, 32'h0000_0005);
      rd(PMD_OFF_TEMP_SEL, 32'h0000_0004);
   endtask
   // ==========================================================================
   // Main sequence and watchdog
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_triggers();
      t_never();
      t_pol();
      t_hyst();
      t_inputs();
      t_temp();
      complete_run();
   end
   initial begin
      #100000;
      err_total++;
      complete_run();
   end
endmodule
`default_nettype wire

// >>> verification/pmd_pins_model.sv
// Model of the button, auxiliary switch and pulled-up loads on the digital pins.
`timescale 1ns/100ps
`default_nettype none
module pmd_pins_model (
   // Switch levels chosen by the bench
   input wire logic press,
   input wire logic aux_level,
   // Sink drive from the block
   input wire logic out_one,
   input wire logic out_one_oe,
   input wire logic out_two,
   input wire logic out_two_oe,
   // Pins and load terminals
   output logic button_input,
   output logic aux_input,
   output logic term_one,
   output logic term_two
);
   assign button_input = press;
   assign aux_input = aux_level;
   // The load pulls its terminal up, so only a closed switch can pull it low.
   assign term_one = out_one_oe ? out_one : 1'b1;
   assign term_two = out_two_oe ? out_two : 1'b1;
endmodule
`default_nettype wire

// >>> verilog/pmd_digital_io.sv
// Top of the pack monitor digital input/output block with APB registers.
//
// Contract
// - Each output trigger code: 0 never, 1 over temp, 2 over volt, 3 overload.
// - Trigger never means output changes only by software command.
// - Reset gives active high polarity and trigger never on both outputs.
// - Predefined trigger drives output active while its condition holds.
// - Over temperature releases only below limit minus hysteresis.
// - Undervoltage and protection events never force outputs off.
// - Each output polarity is independently active high or active low; here the bit is only stored and read back, the pins ignore it.
// - Software can read activated state of both outputs.
// - Active output turns on low side switch; inactive leaves terminal open.
// - Button input defaults to operating mode; aux input defaults disabled.
// - Aux polarity high reads high as active; low polarity inverts.
// - Temperature index 1 internal, 2 to 4 external first to third.
// - Wake from button; aux input may wake when enabled.
// - Aux polarity code 0 active high, 1 active low.
`timescale 1ns/100ps
`default_nettype none
module pmd_digital_io
   import pmd_pkg::*;
#(
   parameter int TEMP_W = PMD_TEMP_W
) (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Measurements and conditions
   input wire logic [TEMP_W-1:0] temp_internal,
   input wire logic [TEMP_W-1:0] external_temp_first,
   input wire logic [TEMP_W-1:0] external_temp_second,
   input wire logic [TEMP_W-1:0] external_temp_third,
   input wire logic over_volt,
   input wire logic overload,
   // Pins
   input wire logic button_input,
   input wire logic aux_input,
   output logic general_output_one,
   output logic general_output_two,
   output logic general_output_one_oe,
   output logic general_output_two_oe,
   // Input results
   output logic button_active,
   output logic aux_active,
   output logic wake_request
);
   logic [1:0] trig1, trig2;
   logic pol1, pol2;
   logic [3:0] fn1, fn2;
   logic aux_pol;
   logic aux_wake_en;
   logic [TEMP_W-1:0] temp_limit, temp_hyst;
   logic [2:0] temp_idx;
   logic over_temp;
   logic [1:0] btn_sync, aux_sync;
   logic act1, act2;
   logic cmd1_set, cmd2_set;
   logic wr, rd, addr_ok;
   logic [31:0] next_rdata;
   logic [TEMP_W-1:0] sel_temp;
   logic [TEMP_W:0] release_thr;

   // ==========================================================================
   // Bus decode
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;
   always_comb begin
      unique case (paddr)
         PMD_OFF_OUT_CFG, PMD_OFF_OUT_CMD, PMD_OFF_OUT_STAT, PMD_OFF_IN_CFG,
         PMD_OFF_IN_STAT, PMD_OFF_TEMP_LIMIT, PMD_OFF_TEMP_SEL,
         PMD_OFF_TEMP_READ: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !addr_ok;
   assign cmd1_set = wr && paddr == PMD_OFF_OUT_CMD && pstrb[0] && pwdata[1];
   assign cmd2_set = wr && paddr == PMD_OFF_OUT_CMD && pstrb[0] && pwdata[3];

   // ==========================================================================
   // Output configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig1 <= PMD_TRIG_NEVER;
         trig2 <= PMD_TRIG_NEVER;
         pol1 <= PMD_POL_HIGH;
         pol2 <= PMD_POL_HIGH;
      end else if (wr && paddr == PMD_OFF_OUT_CFG && pstrb[0]) begin
         trig1 <= pwdata[PMD_CFG_TRIG1_LSB +: 2];
         pol1 <= pwdata[PMD_CFG_POL1_BIT];
         trig2 <= pwdata[PMD_CFG_TRIG2_LSB +: 2];
         pol2 <= pwdata[PMD_CFG_POL2_BIT];
      end
   end

   // ==========================================================================
   // Input configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fn1 <= PMD_FN_OP_MODE;
         fn2 <= PMD_FN_DISABLED;
         aux_pol <= PMD_POL_HIGH;
         aux_wake_en <= 1'b0;
      end else if (wr && paddr == PMD_OFF_IN_CFG) begin
         if (pstrb[0] && pwdata[PMD_IN_FN1_LSB +: 4] <= PMD_FN_MAX) begin
            fn1 <= pwdata[PMD_IN_FN1_LSB +: 4];
         end
         if (pstrb[0] && pwdata[PMD_IN_FN2_LSB +: 4] <= PMD_FN_MAX) begin
            fn2 <= pwdata[PMD_IN_FN2_LSB +: 4];
         end
         if (pstrb[1]) begin
            aux_pol <= pwdata[PMD_IN_POL2_BIT];
            aux_wake_en <= pwdata[PMD_IN_WAKE2_BIT];
         end
      end
   end

   // ==========================================================================
   // Temperature limit, hysteresis and index
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_limit <= PMD_TEMP_LIMIT_RST;
         temp_hyst <= PMD_TEMP_HYST_RST;
      end else if (wr && paddr == PMD_OFF_TEMP_LIMIT) begin
         temp_limit <= pwdata[TEMP_W-1:0];
         temp_hyst <= pwdata[PMD_HYST_LSB +: TEMP_W];
      end
   end

   // Indices outside 1..4 are ignored so the readback never points nowhere.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         temp_idx <= PMD_TEMP_IDX_MIN;
      end else if (wr && paddr == PMD_OFF_TEMP_SEL && pstrb[0] &&
            pwdata[2:0] >= PMD_TEMP_IDX_MIN && pwdata[2:0] <= PMD_TEMP_IDX_MAX) begin
         temp_idx <= pwdata[2:0];
      end
   end

   always_comb begin
      unique case (temp_idx)
         3'h1: sel_temp = temp_internal;
         3'h2: sel_temp = external_temp_first;
         3'h3: sel_temp = external_temp_second;
         3'h4: sel_temp = external_temp_third;
         default: sel_temp = temp_internal;
      endcase
   end

   // ==========================================================================
   // Over temperature with hysteresis on the internal board sensor
   // Release threshold is kept one bit wider so a hysteresis above the limit cannot wrap.
   assign release_thr = {1'b0, temp_limit} - {1'b0, temp_hyst};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         over_temp <= 1'b0;
      end else if (temp_internal > temp_limit) begin
         over_temp <= 1'b1;
      end else if (!release_thr[TEMP_W] && {1'b0, temp_internal} < release_thr) begin
         over_temp <= 1'b0;
      end
   end

   property p_temp_hold;
      @(posedge pclk) disable iff (!presetn)
         over_temp && temp_internal >= release_thr[TEMP_W-1:0] && !release_thr[TEMP_W]
         |=> over_temp;
   endproperty
   a_temp_hold: assert property (p_temp_hold) else $error("over temp released early");

   // ==========================================================================
   // Output channels
   pmd_out_channel u_out_one (
      .pclk(pclk),
      .presetn(presetn),
      .trig_sel(trig1),
      .pol_low(pol1),
      .user_set(cmd1_set),
      .user_val(pwdata[0]),
      .over_temp(over_temp),
      .over_volt(over_volt),
      .overload(overload),
      .active(act1),
      .level(),
      .sink_on(general_output_one_oe)
   );
   pmd_out_channel u_out_two (
      .pclk(pclk),
      .presetn(presetn),
      .trig_sel(trig2),
      .pol_low(pol2),
      .user_set(cmd2_set),
      .user_val(pwdata[2]),
      .over_temp(over_temp),
      .over_volt(over_volt),
      .overload(overload),
      .active(act2),
      .level(),
      .sink_on(general_output_two_oe)
   );
   // Open drain terminals: driven low when the switch is on, open otherwise.
   assign general_output_one = 1'b0;
   assign general_output_two = 1'b0;

   property p_trig_follow;
      @(posedge pclk) disable iff (!presetn)
         trig1 == PMD_TRIG_OVER_VOLT && $stable(trig1) |-> act1 == $past(over_volt);
   endproperty
   a_trig_follow: assert property (p_trig_follow) else $error("output one ignores voltage");
   property p_never_hold;
      @(posedge pclk) disable iff (!presetn)
         trig2 == PMD_TRIG_NEVER && $past(trig2) == PMD_TRIG_NEVER && !$past(cmd2_set)
         && $past(trig2, 2) == PMD_TRIG_NEVER && !$past(cmd2_set, 2) |-> $stable(act2);
   endproperty
   a_never_hold: assert property (p_never_hold) else $error("output two changed alone");

   // ==========================================================================
   // Input synchronisers and polarity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         btn_sync <= 2'h0;
         aux_sync <= 2'h0;
      end else begin
         btn_sync <= {btn_sync[0], button_input};
         aux_sync <= {aux_sync[0], aux_input};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         button_active <= 1'b0;
         aux_active <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         button_active <= btn_sync[1] && fn1 != PMD_FN_DISABLED;
         // A disabled aux input reports nothing on aux_active, matching its powered-down state.
         aux_active <= (aux_sync[1] ^ aux_pol) && fn2 != PMD_FN_DISABLED;
         wake_request <= btn_sync[1] || (aux_wake_en && (aux_sync[1] ^ aux_pol));
      end
   end

   property p_aux_pol;
      @(posedge pclk) disable iff (!presetn)
         fn2 != PMD_FN_DISABLED && $stable(fn2) && $stable(aux_pol)
         |=> aux_active == ($past(aux_sync[1]) ^ $past(aux_pol));
   endproperty
   a_aux_pol: assert property (p_aux_pol) else $error("aux polarity wrong");
   property p_sync_delay;
      @(posedge pclk) disable iff (!presetn)
         $rose(button_input) ##1 button_input ##1 button_input |=> wake_request;
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("button wake missing");

   // ==========================================================================
   // Read data
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         PMD_OFF_OUT_CFG: begin
            next_rdata[PMD_CFG_TRIG1_LSB +: 2] = trig1;
            next_rdata[PMD_CFG_POL1_BIT] = pol1;
            next_rdata[PMD_CFG_TRIG2_LSB +: 2] = trig2;
            next_rdata[PMD_CFG_POL2_BIT] = pol2;
         end
         PMD_OFF_OUT_STAT: next_rdata[1:0] = {act2, act1};
         PMD_OFF_IN_CFG: begin
            next_rdata[PMD_IN_FN1_LSB +: 4] = fn1;
            next_rdata[PMD_IN_FN2_LSB +: 4] = fn2;
            next_rdata[PMD_IN_POL2_BIT] = aux_pol;
            next_rdata[PMD_IN_WAKE2_BIT] = aux_wake_en;
         end
         PMD_OFF_IN_STAT: next_rdata[3:0] = {over_temp, wake_request, aux_active, button_active};
         PMD_OFF_TEMP_LIMIT: begin
            next_rdata[TEMP_W-1:0] = temp_limit;
            next_rdata[PMD_HYST_LSB +: TEMP_W] = temp_hyst;
         end
         PMD_OFF_TEMP_SEL: next_rdata[2:0] = temp_idx;
         PMD_OFF_TEMP_READ: next_rdata[TEMP_W-1:0] = sel_temp;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;
      end
   end

   property p_stat_read;
      @(posedge pclk) disable iff (!presetn)
         psel && !penable && !pwrite && paddr == PMD_OFF_OUT_STAT
         |=> prdata[1:0] == $past({act2, act1});
   endproperty
   a_stat_read: assert property (p_stat_read) else $error("status read wrong");
endmodule
`default_nettype wire

// >>> verilog/pmd_out_channel.sv
// One general purpose output channel with trigger, latch and polarity.
`timescale 1ns/100ps
`default_nettype none
module pmd_out_channel
   import pmd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Configuration
   input wire logic [1:0] trig_sel,
   input wire logic pol_low,
   input wire logic user_set,
   input wire logic user_val,
   // Conditions
   input wire logic over_temp,
   input wire logic over_volt,
   input wire logic overload,
   // Result
   output logic active,
   output logic level,
   output logic sink_on
);
   logic user_state;
   logic cond;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         user_state <= 1'b0;
      end else if (user_set) begin
         user_state <= user_val;
      end
   end

   always_comb begin
      unique case (pmd_trig_t'(trig_sel))
         PMD_TRIG_NEVER: cond = user_state;
         PMD_TRIG_OVER_TEMP: cond = over_temp;
         PMD_TRIG_OVER_VOLT: cond = over_volt;
         PMD_TRIG_OVERLOAD: cond = overload;
      endcase
   end

   // Undervoltage and other protection events never enter here.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 1'b0;
         level <= 1'b0;
         sink_on <= 1'b0;
      end else begin
         active <= cond;
         level <= cond ^ pol_low;
         sink_on <= cond;
      end
   end

   property p_sink_follows;
      @(posedge pclk) disable iff (!presetn) sink_on == active;
   endproperty
   a_sink_follows: assert property (p_sink_follows) else $error("sink not tied to state");
   property p_level_pol;
      @(posedge pclk) disable iff (!presetn) $stable(pol_low) |-> level == (active ^ $past(pol_low));
   endproperty
   a_level_pol: assert property (p_level_pol) else $error("output level polarity wrong");
endmodule
`default_nettype wire

// >>> verilog/pmd_pkg.sv
// Package of constants for the pack monitor digital input/output block.
package pmd_pkg;
   // ==========================================================================
   // Register byte offsets
   localparam logic [11:0] PMD_OFF_OUT_CFG = 12'h000;
   localparam logic [11:0] PMD_OFF_OUT_CMD = 12'h004;
   localparam logic [11:0] PMD_OFF_OUT_STAT = 12'h008;
   localparam logic [11:0] PMD_OFF_IN_CFG = 12'h00c;
   localparam logic [11:0] PMD_OFF_IN_STAT = 12'h010;
   localparam logic [11:0] PMD_OFF_TEMP_LIMIT = 12'h014;
   localparam logic [11:0] PMD_OFF_TEMP_SEL = 12'h018;
   localparam logic [11:0] PMD_OFF_TEMP_READ = 12'h01c;
   // ==========================================================================
   // Trigger codes
   typedef enum logic [1:0] {
      PMD_TRIG_NEVER = 2'h0,
      PMD_TRIG_OVER_TEMP = 2'h1,
      PMD_TRIG_OVER_VOLT = 2'h2,
      PMD_TRIG_OVERLOAD = 2'h3
   } pmd_trig_t;
   // ==========================================================================
   // Input function codes
   localparam logic [3:0] PMD_FN_DISABLED = 4'h0;
   localparam logic [3:0] PMD_FN_OP_MODE = 4'h2;
   localparam logic [3:0] PMD_FN_MAX = 4'h9;
   // ==========================================================================
   // Polarity and reset values
   localparam logic PMD_POL_HIGH = 1'b0;
   localparam logic PMD_POL_LOW = 1'b1;
   localparam int PMD_TEMP_W = 12;
   localparam logic [PMD_TEMP_W-1:0] PMD_TEMP_LIMIT_RST = 12'h000;
   localparam logic [PMD_TEMP_W-1:0] PMD_TEMP_HYST_RST = 12'h000;
   localparam logic [2:0] PMD_TEMP_IDX_MIN = 3'h1;
   localparam logic [2:0] PMD_TEMP_IDX_MAX = 3'h4;
   // ==========================================================================
   // Configuration field positions
   localparam int PMD_CFG_TRIG1_LSB = 0;
   localparam int PMD_CFG_POL1_BIT = 2;
   localparam int PMD_CFG_TRIG2_LSB = 4;
   localparam int PMD_CFG_POL2_BIT = 6;
   localparam int PMD_IN_FN1_LSB = 0;
   localparam int PMD_IN_FN2_LSB = 4;
   localparam int PMD_IN_POL2_BIT = 8;
   localparam int PMD_IN_WAKE2_BIT = 9;
   localparam int PMD_HYST_LSB = 16;
endpackage
